/* File: core/fsi_status.sv */
// Top of the fieldbus status indicator: register slave, indicators, text display.
// Assumes fault inputs from the protocol engine are synchronous to aclk.
module fsi_status #(
	parameter int unsigned FRAME_CYC = fsi_pkg::FRAME_CYC,
	parameter int unsigned BLINK_CYC = fsi_pkg::BLINK_CYC,
	parameter int unsigned HOLD_CYC = fsi_pkg::HOLD_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [fsi_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [fsi_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Protocol engine status.
	input wire logic dup_addr,
	input wire logic retry_exceeded,
	input wire logic devs_offline,
	input wire logic dev_err,
	input wire logic slave_cfg_err,
	input wire logic all_exchanging,
	input wire logic valid_frame,
	// Indicators and display.
	output logic bus_fault_indicator_red,
	output logic bus_fault_indicator_green,
	output logic health_red,
	output logic health_green,
	output logic run_red,
	output logic run_green,
	output logic [4:0] disp_msg,
	output logic [31:0] disp_name
);
	// Byte-lane merge of a write into a register word.
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	// Next pending message after the current one, wrapping round.
	function automatic logic [4:0] next_msg(input logic [fsi_pkg::NUM_MSG-1:0] pend, input logic [4:0] cur);
		logic [4:0] res;
		logic found;
		int k;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= fsi_pkg::NUM_MSG; i++) begin
			k = (int'(cur) + i) % fsi_pkg::NUM_MSG;
			if (!found && pend[k]) begin
				res = 5'(k);
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_msg

	fsi_tick_if tk();

	fsi_ticker #(.BLINK_CYC(BLINK_CYC), .HOLD_CYC(HOLD_CYC)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk.src)
	);

	logic [fsi_pkg::CTRL_W-1:0] ctrl_q;
	logic [31:0] name_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [fsi_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] frame_cnt_q;
	logic bf_r_q;
	logic bf_g_q;
	logic hl_r_q;
	logic hl_g_q;
	logic run_r_q;
	logic run_g_q;
	logic [4:0] msg_q;
	logic [fsi_pkg::NUM_MSG-1:0] pend;

	// Control fields decoded from the control register.
	wire [1:0] role = ctrl_q[fsi_pkg::CTRL_ROLE_LSB +: 2];
	wire [1:0] net = ctrl_q[fsi_pkg::CTRL_NET_LSB +: 2];
	wire self_test = ctrl_q[fsi_pkg::CTRL_SELFTEST];
	wire booted = ctrl_q[fsi_pkg::CTRL_BOOTED];
	wire hw_fault = ctrl_q[fsi_pkg::CTRL_HWFAULT];
	wire cfg_ok = ctrl_q[fsi_pkg::CTRL_CFG];
	wire active = ctrl_q[fsi_pkg::CTRL_ACTIVE];
	wire is_slave = role == fsi_pkg::ROLE_SLAVE;
	wire is_master = !is_slave;
	wire is_redund = role == fsi_pkg::ROLE_REDUND;
	wire blink = tk.blink;

	// Write path: address and data are taken in either order, then committed.
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	wire do_wr = aw_hold_q && w_hold_q && !bvalid_q;
	wire wr_ctrl = do_wr && awaddr_q[3:2] == fsi_pkg::REG_CTRL[3:2];
	wire wr_name = do_wr && awaddr_q[3:2] == fsi_pkg::REG_NAME[3:2];
	wire wr_stat = do_wr && awaddr_q[3:2] == fsi_pkg::REG_STATUS[3:2];
	wire [31:0] ctrl_wr = apply_strb({23'h0, ctrl_q}, wdata_q, wstrb_q);
	wire [31:0] name_wr = apply_strb(name_q, wdata_q, wstrb_q);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Write channel holding registers and response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= fsi_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wr_ctrl || wr_name || wr_stat) ? fsi_pkg::RESP_OKAY : fsi_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software-written registers; the status word is read only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= fsi_pkg::CTRL_RST;
			name_q <= fsi_pkg::NAME_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_wr[fsi_pkg::CTRL_W-1:0];
			end
			if (wr_name) begin
				name_q <= name_wr;
			end
		end
	end

	// Read path: one word per aligned address, unmapped answers SLVERR.
	wire tmo = frame_cnt_q == FRAME_CYC;
	wire [31:0] status_word = {19'h0, msg_q, 1'b0, tmo, run_g_q, run_r_q, hl_g_q, hl_r_q, bf_g_q, bf_r_q};
	wire [1:0] rd_idx = s_axi_araddr[3:2];
	wire rd_ctrl = rd_idx == fsi_pkg::REG_CTRL[3:2];
	wire rd_name = rd_idx == fsi_pkg::REG_NAME[3:2];
	wire rd_stat = rd_idx == fsi_pkg::REG_STATUS[3:2];
	wire [31:0] rd_word = rd_ctrl ? {23'h0, ctrl_q} : rd_name ? name_q : rd_stat ? status_word : 32'h0;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Read data register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= fsi_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= (rd_ctrl || rd_name || rd_stat) ? fsi_pkg::RESP_OKAY : fsi_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Frame watchdog: restarts on each valid frame, saturates at the timeout.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_cnt_q <= 32'h0;
		end else if (valid_frame) begin
			frame_cnt_q <= 32'h0;
		end else if (!tmo) begin
			frame_cnt_q <= frame_cnt_q + 32'h1;
		end
	end

	// Bus fault indicator next state for both roles.
	wire bus_err = dup_addr || retry_exceeded || devs_offline;
	wire m_bf_r = bus_err || (dev_err && blink);
	wire s_flash = !tmo && slave_cfg_err;
	wire s_green = !tmo && !slave_cfg_err && all_exchanging;
	wire s_bf_r = tmo || (s_flash && blink);
	wire s_bf_g = s_green && (net == fsi_pkg::NET_OPERATE || (net == fsi_pkg::NET_CLEAR && blink));
	wire bf_r_d = is_slave ? s_bf_r : m_bf_r;
	wire bf_g_d = is_slave && s_bf_g;

	// Health and run indicators next state.
	wire hl_r_d = hw_fault;
	wire hl_g_d = !hw_fault && booted && (cfg_ok || blink);
	wire run_r_d = is_master && net == fsi_pkg::NET_STOP;
	wire run_g_d = is_master && (net == fsi_pkg::NET_OPERATE || (net == fsi_pkg::NET_CLEAR && blink));

	// Indicator drive registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{bf_r_q, bf_g_q, hl_r_q, hl_g_q, run_r_q, run_g_q} <= 6'h00;
		end else begin
			{bf_r_q, bf_g_q, hl_r_q, hl_g_q, run_r_q, run_g_q} <= {bf_r_d, bf_g_d, hl_r_d, hl_g_d, run_r_d, run_g_d};
		end
	end

	assign bus_fault_indicator_red = bf_r_q;
	assign bus_fault_indicator_green = bf_g_q;
	assign health_red = hl_r_q;
	assign health_green = hl_g_q;
	assign run_red = run_r_q;
	assign run_green = run_g_q;

	// Messages that currently apply; the test message is shown alone.
	assign pend[fsi_pkg::MSG_TEST] = 1'b0;
	assign pend[fsi_pkg::MSG_OK] = booted && !hw_fault;
	assign pend[fsi_pkg::MSG_STOP] = net == fsi_pkg::NET_STOP;
	assign pend[fsi_pkg::MSG_OPERATE] = net == fsi_pkg::NET_OPERATE;
	assign pend[fsi_pkg::MSG_CLEAR] = net == fsi_pkg::NET_CLEAR;
	assign pend[fsi_pkg::MSG_OFFLINE] = net == fsi_pkg::NET_OFFLINE;
	assign pend[fsi_pkg::MSG_DEV_FAULT] = is_slave && (dev_err || slave_cfg_err);
	assign pend[fsi_pkg::MSG_COMMS_FAULT] = is_slave && tmo;
	assign pend[fsi_pkg::MSG_BUS_FAULT] = is_master && (retry_exceeded || devs_offline);
	assign pend[fsi_pkg::MSG_SLV_DEV_FAULT] = is_master && dev_err;
	assign pend[fsi_pkg::MSG_MASTER] = is_master;
	assign pend[fsi_pkg::MSG_SLAVE] = is_slave;
	assign pend[fsi_pkg::MSG_DUP_STATION] = dup_addr;
	assign pend[fsi_pkg::MSG_RED_ACTIVE] = is_redund && active;
	assign pend[fsi_pkg::MSG_RED_STANDBY] = is_redund && !active;
	assign pend[fsi_pkg::MSG_NO_CONFIG] = !cfg_ok;
	assign pend[fsi_pkg::MSG_NAME] = 1'b1;
	wire msg_stale = !pend[msg_q];
	wire [4:0] msg_next = next_msg(pend, msg_q);

	// Display message: advance on the hold tick, leave at once a lapsed one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msg_q <= fsi_pkg::MSG_TEST;
		end else if (self_test) begin
			msg_q <= fsi_pkg::MSG_TEST;
		end else if (tk.hold_tick || msg_stale) begin
			msg_q <= msg_next;
		end
	end

	assign disp_msg = msg_q;
	assign disp_name = name_q;

	// Checks on indicator, display and watchdog behaviour.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_dup_solid_red: assert property (is_master && dup_addr |=> bf_r_q && !bf_g_q)
		else $error("duplicate address did not give solid red");
	a_dev_err_flash: assert property (is_master && !bus_err && dev_err |=> bf_r_q == $past(blink))
		else $error("device error did not flash red");
	a_master_dark: assert property (is_master && !bus_err && !dev_err |=> !bf_r_q && !bf_g_q)
		else $error("bus fault indicator lit without errors");
	a_frame_restart: assert property (valid_frame |=> frame_cnt_q == 32'h0 ##1 !tmo)
		else $error("valid frame did not restart watchdog");
	a_slave_tmo_red: assert property (is_slave && tmo |=> bf_r_q && !bf_g_q)
		else $error("frame timeout did not give solid red");
	a_slave_cfg_flash: assert property (is_slave && !tmo && slave_cfg_err |=> bf_r_q == $past(blink) && !bf_g_q)
		else $error("unconfigured slave did not flash red");
	a_slave_operate: assert property (is_slave && s_green && net == fsi_pkg::NET_OPERATE |=> bf_g_q && !bf_r_q)
		else $error("operate state did not give solid green");
	a_health_red: assert property (hw_fault |=> hl_r_q && !hl_g_q)
		else $error("hardware fault did not give red health");
	a_health_flash: assert property (booted && !hw_fault && !cfg_ok |=> hl_g_q == $past(blink))
		else $error("health did not flash green without config");
	a_health_solid: assert property (booted && !hw_fault && cfg_ok |=> hl_g_q)
		else $error("health not solid green with config");
	a_test_shown: assert property (self_test |=> msg_q == fsi_pkg::MSG_TEST)
		else $error("self-test message not shown");
	a_stop_run_red: assert property (is_master && net == fsi_pkg::NET_STOP |=> run_r_q && !run_g_q)
		else $error("stop state did not give red run indicator");

	// Further checks on bus faults, health and the watchdog.
	a_retry_red: assert property (is_master && retry_exceeded |=> bf_r_q && !bf_g_q)
		else $error("retry limit did not give solid red");
	a_offline_red: assert property (is_master && devs_offline |=> bf_r_q && !bf_g_q)
		else $error("offline devices did not give solid red");
	a_master_red_only: assert property (is_master |=> !bf_g_q)
		else $error("bus fault indicator green in master role");
	a_slave_clear: assert property (is_slave && !tmo && !slave_cfg_err && all_exchanging &&
		net == fsi_pkg::NET_CLEAR |=> bf_g_q == $past(blink) && !bf_r_q)
		else $error("clear state did not flash green");
	a_health_ok: assert property (!hw_fault |=> !hl_r_q)
		else $error("health red without a hardware fault");
	a_frame_expiry: assert property (frame_cnt_q == FRAME_CYC - 1 && !valid_frame |=> tmo)
		else $error("watchdog did not expire after the timeout span");

	// Pending set one cycle back, so the shown message can be judged against it.
	logic [fsi_pkg::NUM_MSG-1:0] pend_q;
	always_ff @(posedge aclk) begin
		pend_q <= pend;
	end
	a_msg_applies: assert property ($past(aresetn) && !$past(self_test) |-> pend_q[msg_q])
		else $error("display shows a message that does not apply");

	c_msg_advance: cover property (!self_test && tk.hold_tick ##1 msg_q != $past(msg_q));
	c_slave_timeout: cover property (is_slave && !tmo ##1 tmo);
	c_test_to_ok: cover property (self_test ##1 !self_test && booted ##[1:40] msg_q == fsi_pkg::MSG_OK);
	c_slave_clear: cover property (is_slave && s_green && net == fsi_pkg::NET_CLEAR);
endmodule : fsi_status

/* File: core/fsi_pkg.sv */
// Constants, register map and message codes of the fieldbus status indicator.
// Assumes a single 125 MHz module clock and an AXI4-Lite register bus.
// Operation
// - Master: duplicate node address gives solid red
// - Master: device errors only give flashing red
// - Master: dark only without bus or device errors
// - Slave: no valid frame over 1s, solid red
// - Slave: unconfigured emulated slave gives flashing red
// - Slave: all exchanging, CLEAR flashes, OPERATE solid green
// - Health red when module is faulty
// - Health flashes green when booted without configuration
// - Health solid green when booted with configuration
// - Self-test running shows the test message
// - Successful boot shows the boot-success message
// - Display names the current network state
// - Slave: faulty emulated slave shows device fault
// - Slave: failed bus communication shows comms fault
// - Master: failed bus communication shows bus fault
// - Master: faulty remote slave shows slave-device fault
// - Display names the master or slave role
// - Conflicting node address shows duplicate station
// - Redundant master shows active or standby
// - Missing configuration shows no-configuration message
// - Display also shows the instance name
// - Master: retry limit exceeded gives solid red
// - Master: devices offline gives solid red
// - Master: network STOP makes run indicator red
package fsi_pkg;
	// Clock rate and timing figures.
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned FRAME_TIMEOUT_MS = 1000;
	localparam int unsigned FRAME_CYC = FRAME_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned BLINK_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned MSG_HOLD_MS = 1500;
	localparam int unsigned HOLD_CYC = MSG_HOLD_MS * (CLK_HZ / 1000);
	// Register map.
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_NAME = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [31:0] NAME_RST = 32'h0000_0000;
	localparam int CTRL_ROLE_LSB = 0;
	localparam int CTRL_NET_LSB = 2;
	localparam int CTRL_SELFTEST = 4;
	localparam int CTRL_BOOTED = 5;
	localparam int CTRL_HWFAULT = 6;
	localparam int CTRL_CFG = 7;
	localparam int CTRL_ACTIVE = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Role and network state encodings.
	localparam logic [1:0] ROLE_MASTER = 2'h0;
	localparam logic [1:0] ROLE_SLAVE = 2'h1;
	localparam logic [1:0] ROLE_REDUND = 2'h2;
	localparam logic [1:0] NET_STOP = 2'h0;
	localparam logic [1:0] NET_OPERATE = 2'h1;
	localparam logic [1:0] NET_CLEAR = 2'h2;
	localparam logic [1:0] NET_OFFLINE = 2'h3;
	// Text display messages, in cycling order.
	localparam int NUM_MSG = 17;
	typedef enum logic [4:0] {
		MSG_TEST, MSG_OK, MSG_STOP, MSG_OPERATE, MSG_CLEAR, MSG_OFFLINE,
		MSG_DEV_FAULT, MSG_COMMS_FAULT, MSG_BUS_FAULT, MSG_SLV_DEV_FAULT,
		MSG_MASTER, MSG_SLAVE, MSG_DUP_STATION, MSG_RED_ACTIVE,
		MSG_RED_STANDBY, MSG_NO_CONFIG, MSG_NAME
	} fsi_msg_e;
endpackage : fsi_pkg

/* File: core/fsi_tick_if.sv */
// Interface carrying the shared blink phase and message hold tick.
// Assumes both ends run on the module clock.
interface fsi_tick_if;
	logic blink;
	logic hold_tick;
	modport src(output blink, hold_tick);
	modport snk(input blink, hold_tick);
endinterface : fsi_tick_if

/* File: core/fsi_ticker.sv */
// Divider producing the blink phase and the message hold tick.
// Assumes a synchronous active-low reset on the module clock.
module fsi_ticker #(
	parameter int unsigned BLINK_CYC = fsi_pkg::BLINK_CYC,
	parameter int unsigned HOLD_CYC = fsi_pkg::HOLD_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Timing outputs.
	fsi_tick_if.src tk
);
	logic [31:0] blink_cnt_q;
	logic [31:0] hold_cnt_q;
	logic blink_q;
	wire blink_wrap = blink_cnt_q == BLINK_CYC - 1;
	wire hold_wrap = hold_cnt_q == HOLD_CYC - 1;

	// One half period per phase, shared by every flashing indicator.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else begin
			blink_cnt_q <= blink_wrap ? 32'h0 : blink_cnt_q + 32'h1;
			if (blink_wrap) begin
				blink_q <= ~blink_q;
			end
		end
	end

	// Hold interval counter for the text display.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt_q <= 32'h0;
		end else begin
			hold_cnt_q <= hold_wrap ? 32'h0 : hold_cnt_q + 32'h1;
		end
	end

	// Phase is a level, the tick a one-cycle pulse.
	assign tk.blink = blink_q;
	assign tk.hold_tick = hold_wrap;
endmodule : fsi_ticker

/* File: tb/tb_top.sv */
// Self-checking bench for the fieldbus status indicator top module.
// Assumes the design files and package are compiled first; shortened counts are set below.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned FC = 50;
	localparam int unsigned BC = 4;
	localparam int unsigned HC = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, disp_name;
	logic dup = 1'b0, retry = 1'b0, offl = 1'b0, deverr = 1'b0, cfgerr = 1'b0, allx = 1'b0, vf = 1'b0, fen = 1'b1;
	wire [5:0] leds;
	wire [4:0] msg;
	int mismatches = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0000_bad3;

	// Clock of 8 ns period.
	always #4 aclk = ~aclk;

	// Frames arrive every other cycle while enabled.
	always @(posedge aclk) vf <= fen & ~vf;

	fsi_status #(.FRAME_CYC(FC), .BLINK_CYC(BC), .HOLD_CYC(HC)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dup_addr(dup), .retry_exceeded(retry), .devs_offline(offl), .dev_err(deverr),
		.slave_cfg_err(cfgerr), .all_exchanging(allx), .valid_frame(vf),
		.bus_fault_indicator_red(leds[0]), .bus_fault_indicator_green(leds[1]),
		.health_red(leds[2]), .health_green(leds[3]), .run_red(leds[4]), .run_green(leds[5]),
		.disp_msg(msg), .disp_name(disp_name)
	);

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// Compares a seen value with the expected one.
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Xorshift source of repeatable random words.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// One write; handshakes are judged before the edge so the edge itself is race free.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		logic ha, hw, hb;
		n = 0;
		hb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
			n++;
			if (n > 200) begin
				mismatches++;
				tally_and_finish();
			end
		end
	endtask : wr

	// One read, returning data and response.
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ha, hr;
		n = 0;
		hr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr) begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
			n++;
			if (n > 200) begin
				mismatches++;
				tally_and_finish();
			end
		end
	endtask : rd

	// Expected indicator kind: 0 dark, 1 solid, 2 flashing.
	function automatic logic [1:0] led_exp(input int i, input logic [8:0] c, input logic t);
		logic m;
		logic [1:0] nt, g;
		m = c[1:0] != fsi_pkg::ROLE_SLAVE;
		nt = c[3:2];
		g = (nt == fsi_pkg::NET_OPERATE) ? 2'h1 : (nt == fsi_pkg::NET_CLEAR) ? 2'h2 : 2'h0;
		case (i)
			0: return m ? ((dup | retry | offl) ? 2'h1 : deverr ? 2'h2 : 2'h0) : (t ? 2'h1 : cfgerr ? 2'h2 : 2'h0);
			1: return (!m && !t && !cfgerr && allx) ? g : 2'h0;
			2: return {1'b0, c[6]};
			3: return (c[6] || !c[5]) ? 2'h0 : c[7] ? 2'h1 : 2'h2;
			4: return {1'b0, m && nt == fsi_pkg::NET_STOP};
			default: return m ? g : 2'h0;
		endcase
	endfunction : led_exp

	// Expected set of pending display messages.
	function automatic logic [16:0] pend(input logic [8:0] c, input logic t);
		logic [16:0] p;
		logic m, s, rm;
		p = 17'h0;
		s = c[1:0] == fsi_pkg::ROLE_SLAVE;
		m = !s;
		rm = c[1:0] == fsi_pkg::ROLE_REDUND;
		if (c[4]) begin
			p[fsi_pkg::MSG_TEST] = 1'b1;
			return p;
		end
		p[fsi_pkg::MSG_NAME] = 1'b1;
		p[fsi_pkg::MSG_OK] = c[5] & !c[6];
		p[int'(fsi_pkg::MSG_STOP) + int'(c[3:2])] = 1'b1;
		p[fsi_pkg::MSG_DEV_FAULT] = s & (deverr | cfgerr);
		p[fsi_pkg::MSG_COMMS_FAULT] = s & t;
		p[fsi_pkg::MSG_BUS_FAULT] = m & (retry | offl);
		p[fsi_pkg::MSG_SLV_DEV_FAULT] = m & deverr;
		p[fsi_pkg::MSG_MASTER] = m;
		p[fsi_pkg::MSG_SLAVE] = s;
		p[fsi_pkg::MSG_DUP_STATION] = dup;
		p[fsi_pkg::MSG_RED_ACTIVE] = rm & c[8];
		p[fsi_pkg::MSG_RED_STANDBY] = rm & !c[8];
		p[fsi_pkg::MSG_NO_CONFIG] = !c[7];
		return p;
	endfunction : pend

	// Next pending message after the current one, wrapping.
	function automatic int nxt(input logic [16:0] p, input int cur);
		for (int k = 1; k <= 17; k++) begin
			if (p[(cur + k) % 17]) return (cur + k) % 17;
		end
		return cur;
	endfunction : nxt

	// Watches display and indicators over many hold and blink periods.
	task automatic observe(input logic [8:0] c, input logic t);
		logic [16:0] p, seen, care;
		logic [5:0] s0, s1;
		logic [1:0] e;
		int prev;
		p = pend(c, t);
		care = (c[1:0] == fsi_pkg::ROLE_REDUND) ? ~(17'h1 << fsi_pkg::MSG_MASTER) : '1;
		seen = 17'h0;
		s0 = 6'h0;
		s1 = 6'h0;
		prev = -1;
		repeat (20 * HC) begin
			@(negedge aclk);
			seen[msg] = 1'b1;
			s0 = s0 | ~leds;
			s1 = s1 | leds;
			if (prev >= 0 && int'(msg) != prev) check("message order", 32'(msg), 32'(nxt(p, prev)));
			prev = int'(msg);
		end
		check("message set", 32'(seen & care), 32'(p & care));
		for (int i = 0; i < 6; i++) begin
			e = led_exp(i, c, t);
			check($sformatf("indicator %0d", i), {s1[i], s0[i]}, (e == 2'h0) ? 2'h1 : (e == 2'h1) ? 2'h2 : 2'h3);
		end
	endtask : observe

	// Main sequence: registers, watchdog span, then random operating states.
	initial begin
		logic [31:0] d, r;
		logic [1:0] resp;
		logic [8:0] c;
		logic t;
		int n;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(fsi_pkg::REG_CTRL, d, resp);
		check("ctrl reset", d, 32'(fsi_pkg::CTRL_RST));
		rd(fsi_pkg::REG_NAME, d, resp);
		check("name reset", d, fsi_pkg::NAME_RST);
		wr(fsi_pkg::REG_CTRL, 32'hffff_ffff, 4'hf, resp);
		rd(fsi_pkg::REG_CTRL, d, resp);
		check("ctrl width", d, 32'h0000_01ff);
		wr(4'hc, 32'h1234_5678, 4'hf, resp);
		check("unmapped write resp", 32'(resp), 32'(fsi_pkg::RESP_SLVERR));
		rd(4'hc, d, resp);
		check("unmapped read", {resp, d[29:0]}, {fsi_pkg::RESP_SLVERR, 30'h0});
		wr(fsi_pkg::REG_STATUS, 32'hffff_ffff, 4'hf, resp);
		check("status write resp", 32'(resp), 32'(fsi_pkg::RESP_OKAY));
		r = rnd();
		wr(fsi_pkg::REG_NAME, r, 4'hf, resp);
		wr(fsi_pkg::REG_NAME, 32'hc3c3_c3c3, 4'h2, resp);
		rd(fsi_pkg::REG_NAME, d, resp);
		check("name bytes", d, {r[31:16], 8'hc3, r[7:0]});
		check("name read resp", 32'(resp), 32'(fsi_pkg::RESP_OKAY));
		check("display name", disp_name, {r[31:16], 8'hc3, r[7:0]});
		$display("test registers done");
		wr(fsi_pkg::REG_CTRL, 32'h0000_00a1, 4'hf, resp);
		repeat (FC) @(posedge aclk);
		fen <= 1'b0;
		n = 0;
		while (leds[0] !== 1'b1 && n < FC + 10) begin
			@(negedge aclk);
			n++;
		end
		check("frame timeout span", 32'(n >= FC && n <= FC + 3), 32'h1);
		$display("test frame watchdog done");
		for (int it = 0; it < 24; it++) begin
			r = rnd();
			c = r[8:0];
			c[4] = r[9] & r[10] & r[11];
			t = r[12] & r[13];
			wr(fsi_pkg::REG_CTRL, {23'h0, c}, 4'hf, resp);
			r = rnd();
			dup <= r[0] & r[1];
			retry <= r[2] & r[3];
			offl <= r[4] & r[5];
			deverr <= r[6];
			cfgerr <= r[7];
			allx <= r[8];
			fen <= !t;
			repeat (FC + 2 * HC) @(posedge aclk);
			rd(fsi_pkg::REG_STATUS, d, resp);
			check("status timeout", 32'(d[6]), 32'(t));
			observe(c, t);
			$display("test random state %0d done", it);
		end
		tally_and_finish();
	end

	// Watchdog against a hung handshake or display.
	initial begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_top
